// *** hw/asc_defs.svh ***
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

// ==========================================================
// register byte addresses
`define ASC_ADR_CONTROL 8'h00
`define ASC_ADR_ADVERT 8'h04
`define ASC_ADR_STATUS 8'h10
`define ASC_ADR_PARTNER 8'h14

// ==========================================================
// basic_mode_control fields and reset value
`define ASC_CTL_SPEED 13
`define ASC_CTL_AN_EN 12
`define ASC_CTL_RESTART 9
`define ASC_CTL_DUPLEX 8
`define ASC_CTL_RST 16'h3100

// ==========================================================
// phy_status_summary fields
`define ASC_STS_STRAP_AN 9
`define ASC_STS_AN_DONE 4
`define ASC_STS_DUPLEX 2
`define ASC_STS_SPEED10 1

// ==========================================================
// advertisement values
`define ASC_ADV_RST 16'h01E1
`define ASC_ADV_10H 9'h021
`define ASC_ADV_10F 9'h041
`define ASC_ADV_100H 9'h081
`define ASC_ADV_100F 9'h101
`define ASC_ADV_ALL 9'h1E1
`define ASC_ADV_10HF 9'h061
`define ASC_ADV_100HF 9'h181
`define ASC_ADV_HALF 9'h0A1
`define ASC_ABIL_LSB 5

// ==========================================================
// timing counts
`define ASC_SETTLE_CYC 2'h3

`endif

// *** hw/asc_pkg.sv ***
package asc_pkg;

  // ========================================================
  // types
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} asc_lvl_e;

  typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} asc_state_e;

  typedef struct packed {
    logic an;
    logic spd10;
    logic fdx;
    logic [8:0] adv;
  } asc_cfg_s;

  typedef struct packed {
    asc_state_e st;
    logic [1:0] settle;
    logic [15:0] ctl;
    logic [15:0] advert;
    logic [15:0] partner;
    logic [15:0] status;
    logic forced;
    logic sw_owned;
    logic loaded;
    logic ack;
    logic [31:0] rdata;
    logic an_en;
    logic spd100;
    logic fdx;
    logic restart;
    logic [15:0] flp;
  } asc_state_s;

endpackage : asc_pkg

// *** hw/asc_tri_level.sv ***
`timescale 1ns/1ps
`default_nettype none

module asc_tri_level
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cmp_a_i,
  input wire logic cmp_b_i,
  output var asc_lvl_e level_o
);

  // ========================================================
  // two-stage synchroniser for both comparators
  logic [1:0] meta_r;
  logic [1:0] sync_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
    end
    else if (ce_i)
    begin
      meta_r <= {cmp_a_i, cmp_b_i};
      sync_r <= meta_r;
    end
  end

  // ========================================================
  // three-level decode, floating pin reads mid
  always_comb
  begin
    case (sync_r)
      2'h0: level_o = LVL_LOW;
      2'h3: level_o = LVL_HIGH;
      default: level_o = LVL_MID;
    endcase
  end

endmodule : asc_tri_level

`default_nettype wire

// *** hw/asc_an_resolve.sv ***
`timescale 1ns/1ps
`default_nettype none

module asc_an_resolve
  import asc_pkg::*;
(
  input wire logic [3:0] local_i,
  input wire logic [3:0] partner_i,
  output logic valid_o,
  output logic spd100_o,
  output logic fdx_o
);

  // ========================================================
  // highest common ability wins
  logic [3:0] common;

  always_comb
  begin
    common = local_i & partner_i;
    valid_o = |common;
    spd100_o = 1'b0;
    fdx_o = 1'b0;
    if (common[3])
    begin
      spd100_o = 1'b1;
      fdx_o = 1'b1;
    end
    else if (common[2])
    begin
      spd100_o = 1'b1;
    end
    else if (common[1])
    begin
      fdx_o = 1'b1;
    end
  end

endmodule : asc_an_resolve

`default_nettype wire

// *** hw/asc_autoneg_strap_config.sv ***
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"

module asc_autoneg_strap_config
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic strap_select_low_pin_a_i,
  input wire logic strap_select_low_pin_b_i,
  input wire logic strap_select_high_pin_a_i,
  input wire logic strap_select_high_pin_b_i,
  input wire logic [15:0] partner_ability_i,
  input wire logic partner_ability_vld_i,
  input wire logic an_complete_i,
  output logic an_enable_o,
  output logic an_restart_o,
  output logic [15:0] flp_ability_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic strap_loaded_o
);

  // ==========================================================
  // functions
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
      res[7:0] = wd[7:0];
    if (sel[1])
      res[15:8] = wd[15:8];
    return res;
  endfunction : merge16

  function automatic asc_cfg_s strap_decode(input asc_lvl_e hi,
                                            input asc_lvl_e lo);
    asc_cfg_s c;
    c = '{an: 1'b1, spd10: 1'b0, fdx: 1'b0, adv: `ASC_ADV_ALL};
    case ({hi, lo})
      {LVL_LOW, LVL_MID}:
        c = '{an: 1'b0, spd10: 1'b1, fdx: 1'b0, adv: `ASC_ADV_10H};
      {LVL_HIGH, LVL_MID}:
        c = '{an: 1'b0, spd10: 1'b1, fdx: 1'b1, adv: `ASC_ADV_10F};
      {LVL_MID, LVL_LOW}:
        c = '{an: 1'b0, spd10: 1'b0, fdx: 1'b0, adv: `ASC_ADV_100H};
      {LVL_MID, LVL_HIGH}:
        c = '{an: 1'b0, spd10: 1'b0, fdx: 1'b1, adv: `ASC_ADV_100F};
      {LVL_LOW, LVL_LOW}:
        c.adv = `ASC_ADV_10HF;
      {LVL_LOW, LVL_HIGH}:
        c.adv = `ASC_ADV_100HF;
      {LVL_HIGH, LVL_LOW}:
        c.adv = `ASC_ADV_HALF;
      {LVL_HIGH, LVL_HIGH}:
        c.adv = `ASC_ADV_10H;
      default:
        c.adv = `ASC_ADV_ALL;
    endcase
    return c;
  endfunction : strap_decode

  // ==========================================================
  // strap pin resolution
  logic [1:0] cmp_a;
  logic [1:0] cmp_b;
  asc_lvl_e lvl [2];

  assign cmp_a = {strap_select_high_pin_a_i, strap_select_low_pin_a_i};
  assign cmp_b = {strap_select_high_pin_b_i, strap_select_low_pin_b_i};

  for (genvar g = 0; g < 2; g++)
  begin : g_pin
    asc_tri_level u_lvl (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .cmp_a_i(cmp_a[g]),
      .cmp_b_i(cmp_b[g]),
      .level_o(lvl[g])
    );
  end

  asc_cfg_s cfg;

  assign cfg = strap_decode(lvl[1], lvl[0]);

  // ==========================================================
  // state and priority resolution
  asc_state_s s_r;
  asc_state_s s_nxt;
  logic res_vld;
  logic res_spd100;
  logic res_fdx;

  asc_an_resolve u_res (
    .local_i(s_r.advert[8:5]),
    .partner_i(s_r.partner[8:5]),
    .valid_o(res_vld),
    .spd100_o(res_spd100),
    .fdx_o(res_fdx)
  );

  logic take;
  logic [7:0] word_adr;

  assign take = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign word_adr = {wb_adr_i[7:2], 2'h0};

  // ==========================================================
  // next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.restart = 1'b0;
    if (partner_ability_vld_i)
      s_nxt.partner = partner_ability_i;
    s_nxt.status[`ASC_STS_AN_DONE] = an_complete_i;
    case (s_r.st)
      ST_SETTLE:
      begin
        s_nxt.settle = s_r.settle + 2'h1;
        if (s_r.settle == `ASC_SETTLE_CYC - 2'h1)
          s_nxt.st = ST_LOAD;
      end
      ST_LOAD:
      begin
        s_nxt.advert[8:0] = cfg.adv;
        s_nxt.status[`ASC_STS_STRAP_AN] = cfg.an;
        s_nxt.status[`ASC_STS_SPEED10] = cfg.spd10;
        s_nxt.status[`ASC_STS_DUPLEX] = cfg.fdx;
        s_nxt.forced = !cfg.an;
        s_nxt.loaded = 1'b1;
        s_nxt.st = ST_RUN;
      end
      ST_RUN:
        s_nxt.st = ST_RUN;
      default:
        s_nxt.st = ST_SETTLE;
    endcase
    // register bus
    if (take)
    begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = 32'h0;
      case (word_adr)
        `ASC_ADR_CONTROL:
        begin
          s_nxt.rdata[15:0] = s_r.ctl;
          if (wb_we_i)
          begin
            s_nxt.ctl = merge16(s_r.ctl, wb_dat_i, wb_sel_i);
            s_nxt.restart = s_nxt.ctl[`ASC_CTL_RESTART];
            s_nxt.ctl[`ASC_CTL_RESTART] = 1'b0;
            s_nxt.sw_owned = 1'b1;
          end
        end
        `ASC_ADR_ADVERT:
        begin
          s_nxt.rdata[15:0] = s_r.advert;
          if (wb_we_i)
            s_nxt.advert = merge16(s_r.advert, wb_dat_i, wb_sel_i);
        end
        `ASC_ADR_STATUS:
          s_nxt.rdata[15:0] = s_r.status;
        `ASC_ADR_PARTNER:
          s_nxt.rdata[15:0] = s_r.partner;
        default:
          s_nxt.rdata = 32'h0;
      endcase
    end
    // operating mode
    if (s_r.forced && !s_r.sw_owned)
    begin
      s_nxt.an_en = 1'b0;
      s_nxt.spd100 = !s_r.status[`ASC_STS_SPEED10];
      s_nxt.fdx = s_r.status[`ASC_STS_DUPLEX];
    end
    else if (s_r.ctl[`ASC_CTL_AN_EN])
    begin
      s_nxt.an_en = s_r.loaded;
      if (an_complete_i && res_vld)
      begin
        s_nxt.spd100 = res_spd100;
        s_nxt.fdx = res_fdx;
      end
    end
    else
    begin
      s_nxt.an_en = 1'b0;
      s_nxt.spd100 = s_r.ctl[`ASC_CTL_SPEED];
      s_nxt.fdx = s_r.ctl[`ASC_CTL_DUPLEX];
    end
    if (s_r.st == ST_RUN && (s_r.sw_owned || !s_r.forced))
    begin
      s_nxt.status[`ASC_STS_SPEED10] = !s_r.spd100;
      s_nxt.status[`ASC_STS_DUPLEX] = s_r.fdx;
    end
    s_nxt.flp = s_nxt.an_en ? s_nxt.advert : 16'h0;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.st <= ST_SETTLE;
      s_r.ctl <= `ASC_CTL_RST;
      s_r.advert <= `ASC_ADV_RST;
    end
    else if (ce_i)
    begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.rdata;
  assign wb_ack_o = s_r.ack;
  assign an_enable_o = s_r.an_en;
  assign an_restart_o = s_r.restart;
  assign flp_ability_o = s_r.flp;
  assign speed_100_o = s_r.spd100;
  assign full_duplex_o = s_r.fdx;
  assign strap_loaded_o = s_r.loaded;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_ctl_write;
    take && wb_we_i && word_adr == `ASC_ADR_CONTROL && ce_i;
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_reset_default: assert property ($fell(rst_i) |->
    s_r.ctl == `ASC_CTL_RST && s_r.advert == `ASC_ADV_RST)
    else $error("control or advert not at defaults after reset");
  a_advert_load: assert property ($rose(s_r.loaded) |->
    s_r.advert[8:0] == $past(cfg.adv))
    else $error("advert not loaded from straps");
  a_strap_status: assert property ($rose(s_r.loaded) |->
    s_r.status[`ASC_STS_STRAP_AN] == (s_r.advert[8:0] != `ASC_ADV_10F
    && s_r.advert[8:0] != `ASC_ADV_100H
    && s_r.advert[8:0] != `ASC_ADV_100F) || s_r.advert[8:0] == `ASC_ADV_10H)
    else $error("strap status bit inconsistent with advert");
  a_forced_off: assert property (s_r.forced && !s_r.sw_owned && ce_i
    |=> !an_enable_o)
    else $error("negotiation enabled in forced strap mode");
  a_ctl_untouched: assert property ($rose(s_r.loaded) |->
    s_r.ctl == $past(s_r.ctl))
    else $error("strap load changed control register");
  a_ctl_owns: assert property (seq_ctl_write |=> s_r.sw_owned)
    else $error("control write did not take over mode");
  a_manual_mode: assert property (s_r.sw_owned &&
    !s_r.ctl[`ASC_CTL_AN_EN] && ce_i |=> speed_100_o ==
    $past(s_r.ctl[`ASC_CTL_SPEED]) && full_duplex_o ==
    $past(s_r.ctl[`ASC_CTL_DUPLEX]))
    else $error("manual speed or duplex not taken from control");
  a_flp_advert: assert property (an_enable_o |->
    flp_ability_o == s_r.advert ##1 !an_enable_o || flp_ability_o != 16'h0
    || s_r.advert == 16'h0)
    else $error("burst abilities differ from advert");
  a_capture_once: assert property (s_r.st == ST_RUN |=>
    s_r.st == ST_RUN && $stable(s_r.status[`ASC_STS_STRAP_AN]))
    else $error("straps captured again after load");

endmodule : asc_autoneg_strap_config

`default_nettype wire

// *** tb/asc_link_partner_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// far-end station: sends its ability word after a delay
module asc_link_partner_model
  import asc_pkg::*;
#(
  parameter logic [3:0] DLY = 4'h6
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [15:0] abil_i,
  output logic [15:0] ability_o,
  output logic vld_o,
  output logic done_o
);
  logic [3:0] cnt_r;

  always_ff @(posedge clk_i)
  begin
    vld_o <= 1'b0;
    if (rst_i)
    begin
      cnt_r <= 4'h0;
      done_o <= 1'b0;
      ability_o <= 16'hFFFF;
    end
    else if (start_i)
    begin
      cnt_r <= DLY;
      done_o <= 1'b0;
      ability_o <= ~abil_i;
    end
    else if (cnt_r == 4'h1)
    begin
      cnt_r <= 4'h0;
      ability_o <= abil_i;
      vld_o <= 1'b1;
    end
    else if (vld_o)
      done_o <= 1'b1;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule : asc_link_partner_model
`default_nettype wire

// *** tb/asc_autoneg_strap_config_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"

module asc_autoneg_strap_config_tb_top
  import asc_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic lo_a = 1'b0, lo_b = 1'b1, hi_a = 1'b0, hi_b = 1'b1;
  logic [15:0] p_abil, p_word = 16'h0;
  logic p_vld, p_done, p_go = 1'b0;
  logic ack, an_en, rstrt, spd, fdx, loaded;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hF, bsel = 4'hF;
  logic [15:0] flp;
  int fails = 0, cmp_count = 0;
  localparam logic [1:0] HI [9] = '{2'h0, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0,
    2'h0, 2'h3, 2'h3};
  localparam logic [1:0] LO [9] = '{2'h1, 2'h1, 2'h0, 2'h3, 2'h1, 2'h0,
    2'h3, 2'h0, 2'h3};
  localparam logic [8:0] ADV [9] = '{9'h021, 9'h041, 9'h081, 9'h101,
    9'h1E1, 9'h061, 9'h181, 9'h0A1, 9'h021};
  localparam logic [2:0] STS [9] = '{3'h1, 3'h3, 3'h0, 3'h2, 3'h4, 3'h4,
    3'h4, 3'h4, 3'h4};

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  asc_autoneg_strap_config u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .strap_select_low_pin_a_i(lo_a),
    .strap_select_low_pin_b_i(lo_b), .strap_select_high_pin_a_i(hi_a),
    .strap_select_high_pin_b_i(hi_b), .partner_ability_i(p_abil),
    .partner_ability_vld_i(p_vld), .an_complete_i(p_done),
    .an_enable_o(an_en), .an_restart_o(rstrt), .flp_ability_o(flp),
    .speed_100_o(spd), .full_duplex_o(fdx), .strap_loaded_o(loaded));

  asc_link_partner_model u_partner (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(p_go), .abil_i(p_word), .ability_o(p_abil), .vld_o(p_vld),
    .done_o(p_done));

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
  begin
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  end
  endtask : chk

  task automatic chk1(input string nm, input logic e, input logic g);
  begin
    chk(nm, {31'h0, e}, {31'h0, g});
  end
  endtask : chk1

  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= bsel;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk1("ack", 1'b1, ack);
  end
  endtask : bus

  task automatic boot(input logic [1:0] h, input logic [1:0] l);
    int n;
  begin
    n = 0;
    @(posedge clk_i);
    rst_i <= 1'b1;
    {hi_a, hi_b, lo_a, lo_b} <= {h, l};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    while (loaded !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    chk1("loaded", 1'b1, loaded);
  end
  endtask : boot

  task automatic partner(input logic [15:0] w);
    int n;
  begin
    n = 0;
    @(posedge clk_i);
    p_word <= w;
    p_go <= 1'b1;
    @(posedge clk_i);
    p_go <= 1'b0;
    repeat (2) @(posedge clk_i);
    while (p_done !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    repeat (4) @(posedge clk_i);
  end
  endtask : partner

  task automatic close_out();
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask : close_out

  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    close_out();
  end

  initial
  begin
    for (int i = 0; i < 9; i++)
    begin
      boot(HI[i], LO[i]);
      bus(1'b0, `ASC_ADR_ADVERT, 32'h0);
      chk("advert", {23'h0, ADV[i]}, q);
      bus(1'b0, `ASC_ADR_STATUS, 32'h0);
      chk1("strap_an", STS[i][2], q[9]);
      if (!STS[i][2])
      begin
        chk("sts_mode", {30'h0, STS[i][1:0]}, {30'h0, q[2:1]});
        chk1("speed", ~STS[i][0], spd);
        chk1("duplex", STS[i][1], fdx);
      end
      chk1("an_en", STS[i][2], an_en);
      chk("flp", STS[i][2] ? {23'h0, ADV[i]} : 32'h0, {16'h0, flp});
      bus(1'b0, `ASC_ADR_CONTROL, 32'h0);
      chk("control", 32'h3100, q);
      $display("strap case %0d done", i);
    end
    {lo_a, lo_b, hi_a, hi_b} <= 4'h5;
    repeat (10) @(posedge clk_i);
    bus(1'b0, `ASC_ADR_ADVERT, 32'h0);
    chk("held", 32'h021, q);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, `ASC_ADR_CONTROL, 32'h2100);
    repeat (3) @(posedge clk_i);
    chk("forced", 32'h3, {29'h0, an_en, spd, fdx});
    bus(1'b1, `ASC_ADR_CONTROL, 32'h0);
    repeat (3) @(posedge clk_i);
    chk("forced0", 32'h0, {29'h0, an_en, spd, fdx});
    $display("software mode test done");
    boot(2'h1, 2'h1);
    partner(16'h0061);
    chk("neg10", 32'h5, {29'h0, an_en, spd, fdx});
    ce <= 1'b0;
    partner(16'h01E1);
    chk("frozen", 32'h5, {29'h0, an_en, spd, fdx});
    ce <= 1'b1;
    partner(16'h01E1);
    chk("neg100", 32'h7, {29'h0, an_en, spd, fdx});
    bus(1'b0, `ASC_ADR_PARTNER, 32'h0);
    chk("partner", 32'h01E1, q);
    bus(1'b0, `ASC_ADR_STATUS, 32'h0);
    chk("sts_neg", 32'h0214, q);
    bus(1'b1, `ASC_ADR_CONTROL, 32'h1200);
    chk1("restart", 1'b1, rstrt);
    @(posedge clk_i);
    chk1("restart_end", 1'b0, rstrt);
    bus(1'b0, `ASC_ADR_CONTROL, 32'h0);
    chk("ctl_rst", 32'h1000, q);
    chk1("an_kept", 1'b1, an_en);
    bus(1'b1, `ASC_ADR_ADVERT, 32'h0021);
    repeat (2) @(posedge clk_i);
    chk("flp_w", 32'h0021, {16'h0, flp});
    chk("neg_low", 32'h4, {29'h0, an_en, spd, fdx});
    bsel = 4'h2;
    bus(1'b1, `ASC_ADR_ADVERT, 32'h00000100);
    bsel = 4'hF;
    bus(1'b0, `ASC_ADR_ADVERT, 32'h0);
    chk("sel_hi", 32'h0121, q);
    chk("flp_sel", 32'h0121, {16'h0, flp});
    $display("negotiation test done");
    close_out();
  end
endmodule : asc_autoneg_strap_config_tb_top
`default_nettype wire
